/* File: dv/serial_eeprom_monitor.sv */
// link checker: timing and drive rules on the serial eeprom wires
`timescale 1ns/1ps
module serial_eeprom_monitor
   import serial_eeprom_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   // link
   input wire logic chip_select,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic data_out,
   input wire logic data_out_oe_n,
   input wire logic data_out_wire
);
   // a frame is far shorter than this many shift periods
   localparam int CS_HI_MAX = 40 * PERIOD_CYC;
   logic [15:0] cs_lo_reg, cs_lo_next, cs_hi_reg, cs_hi_next;
   logic [15:0] sclk_hi_reg, sclk_hi_next, sclk_lo_reg, sclk_lo_next;
   logic [15:0] per_reg, per_next;

   // saturating run-length counters
   function automatic logic [15:0] bump(logic [15:0] c, logic run);
      if (!run) return 16'h0000;
      return (c == 16'hFFFF) ? c : c + 16'h0001;
   endfunction

   always_comb begin
      cs_lo_next = bump(cs_lo_reg, !chip_select);
      cs_hi_next = bump(cs_hi_reg, chip_select);
      sclk_hi_next = bump(sclk_hi_reg, shift_clock);
      sclk_lo_next = bump(sclk_lo_reg, !shift_clock);
      per_next = bump(per_reg, 1'b1);
      if (shift_clock && sclk_hi_reg == 16'h0000) begin
         per_next = 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_lo_reg <= 16'h0000;
         cs_hi_reg <= 16'h0000;
         sclk_hi_reg <= 16'h0000;
         sclk_lo_reg <= 16'h0000;
         // no earlier rise: the first period after reset is unbounded
         per_reg <= 16'hFFFF;
      end else begin
         cs_lo_reg <= cs_lo_next;
         cs_hi_reg <= cs_hi_next;
         sclk_hi_reg <= sclk_hi_next;
         sclk_lo_reg <= sclk_lo_next;
         per_reg <= per_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   out_released_a: assert property (
      !chip_select [*8] |-> data_out_oe_n && data_out_wire)
      else $error("data out driven while deselected");
   select_drive_a: assert property (
      chip_select [*8] |-> !data_out_oe_n)
      else $error("data out released while selected");
   deselect_gap_a: assert property (
      $rose(chip_select) |-> cs_lo_reg >= DESELECT_CYC)
      else $error("chip select low gap too short");
   high_phase_a: assert property (
      $fell(shift_clock) |-> sclk_hi_reg >= HIGH_CYC)
      else $error("shift clock high phase too short");
   low_phase_a: assert property (
      $rose(shift_clock) |-> sclk_lo_reg >= LOW_CYC)
      else $error("shift clock low phase too short");
   clock_period_a: assert property (
      $rose(shift_clock) |-> per_reg >= PERIOD_CYC)
      else $error("shift clock period too short");
   select_toggles_a: assert property (
      chip_select |-> cs_hi_reg < CS_HI_MAX)
      else $error("chip select held high too long");
   select_end_a: assert property (
      $fell(chip_select) |-> !shift_clock)
      else $error("chip select fell with shift clock high");
   select_setup_a: assert property (
      $rose(chip_select) |-> !shift_clock [*8])
      else $error("shift clock rose too soon after select");
endmodule // serial_eeprom_monitor

/* File: dv/tb_top.sv */
// self-checking bench: master and device ends joined across the link
`timescale 1ns/1ps
module tb_top;
   import serial_eeprom_pkg::*;
   localparam int PROG = 200;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic [1:0] req_opcode = 2'h0;
   logic [5:0] req_addr = 6'h00;
   logic [15:0] req_data = 16'h0000;
   logic req_ready, rsp_valid, dev_ready, busy, write_enabled;
   logic [15:0] rsp_data, d1, d2;
   logic [15:0] exp_q[$];
   logic [3:0] a;
   logic [1:0] r;
   int error_cnt = 0;
   int checked = 0;

   serial_eeprom_if link();
   serial_eeprom_master i_serial_eeprom_master (.clk(clk), .rst_n(rst_n),
      .clk_en(1'b1), .link(link), .req_valid(req_valid),
      .req_opcode(req_opcode), .req_addr(req_addr), .req_data(req_data),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .dev_ready(dev_ready));
   serial_eeprom_dev #(.PROG_CYCLES(PROG)) i_serial_eeprom_dev (.clk(clk),
      .rst_n(rst_n), .clk_en(1'b1), .link(link), .busy(busy),
      .write_enabled(write_enabled));
   serial_eeprom_monitor i_serial_eeprom_monitor (.clk(clk), .rst_n(rst_n),
      .chip_select(link.chip_select), .shift_clock(link.shift_clock),
      .serial_in(link.serial_in), .data_out(link.data_out),
      .data_out_oe_n(link.data_out_oe_n),
      .data_out_wire(link.data_out_wire));

   always #4 clk = ~clk;

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one frame; counts busy cycles until the device is ready again
   task automatic run(input logic [1:0] op, input logic [5:0] addr,
      input logic [15:0] data, input logic prog, input logic wen,
      input logic [15:0] exp);
      int n;
      int hi;
      n = 0;
      hi = 0;
      while (req_ready !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) error_cnt++;
      req_valid = 1'b1;
      req_opcode = op;
      req_addr = addr;
      req_data = data;
      if (op == OP_READ) exp_q.push_back(exp);
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      // no new command until the device is ready again
      do begin
         @(negedge clk);
         n++;
         if (busy === 1'b1) hi++;
      end while ((req_ready !== 1'b1 || busy !== 1'b0) && n < 40000);
      if (n >= 40000) error_cnt++;
      cmp_bit(hi != 0, prog);
      cmp_bit(hi <= PROG, 1'b1);
      cmp_bit(write_enabled, wen);
   endtask

   // read answers are paired with the oldest expectation
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=none", $time, rsp_data);
         end else begin
            cmp_word(rsp_data, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (98000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   initial begin
      d1 = 16'($urandom(29));
      d1 = 16'($urandom());
      d2 = ~d1;
      a = 4'($urandom_range(15, 0));
      r = 2'($urandom_range(3, 0));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      // don't-care address bits carry random values on array access
      run(OP_EXT, {EXT_ENABLE, a}, d2, 1'b0, 1'b1, 16'h0000);
      run(OP_EXT, {EXT_WRALL, a}, d2, 1'b1, 1'b1, 16'h0000);
      run(OP_ERASE, {r, a}, d1, 1'b1, 1'b1, 16'h0000);
      run(OP_READ, {~r, a}, d2, 1'b0, 1'b1, ERASED_WORD);
      run(OP_WRITE, {r, a}, d1, 1'b1, 1'b1, 16'h0000);
      run(OP_EXT, {EXT_DISABLE, a}, d1, 1'b0, 1'b0, 16'h0000);
      run(OP_ERASE, {r, a}, d2, 1'b0, 1'b0, 16'h0000);
      run(OP_READ, {r, a}, d2, 1'b0, 1'b0, d1);
      run(OP_READ, {~r, a ^ 4'h1}, d1, 1'b0, 1'b0, d2);
      run(OP_EXT, {EXT_ERASE_ALL, a}, d2, 1'b0, 1'b0, 16'h0000);
      repeat (4) @(negedge clk);
      cmp_bit(exp_q.size() == 0, 1'b1);
      cmp_bit(dev_ready, 1'b1);
      end_sim();
   end
endmodule // tb_top

/* File: hw/serial_eeprom_dev.sv */
// eeprom device end: serial command decode, array and programming timer
// What this block does
// - chip select high selects, low deselects
// - select rising edge restarts command decode
// - select falling edge starts pending programming
// - deselected: ignore clock and input, no drive
// - sample serial input on clock rise
// - change output on each clock rise
// - drive output only while selected
// - master deselects at least 1 us
// - master clock at most 250 kHz
// - master keeps each clock phase at least 1 us
// - master shifts command bits on serial input
// - start bit one, leading zeros ignored
// - opcode, address, data, msb first
// - read gives dummy zero then word
// - busy shows zero, ready shows one
`timescale 1ns/1ps
module serial_eeprom_dev
   import serial_eeprom_pkg::*;
#(
   parameter int PROG_CYCLES = PROGRAM_CYC
) (
   // system
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // link
   serial_eeprom_if.device link,
   // status to local logic
   output logic busy,
   output logic write_enabled
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_HDR = 3'b001,
      S_DATA = 3'b011,
      S_READ = 3'b101,
      S_DONE = 3'b111
   } dev_state_t;

   // a zero-length program cycle would wrap the timer compare and hold busy for 2^32 cycles
   if (PROG_CYCLES < 1) begin : g_prog_check
      $error("PROG_CYCLES must be positive");
   end

   // pin synchronisers
   logic [2:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
   logic cs_d_reg, sc_d_reg, cs_d_next, sc_d_next;
   logic cs_s, sc_s, sin_s, cs_rise, cs_fall, sc_rise;

   dev_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [HDR_BITS-1:0] hdr_reg, hdr_next;
   logic [DATA_BITS-1:0] sh_reg, sh_next;
   logic [DATA_BITS-1:0] mem_reg [WORDS];
   logic [DATA_BITS-1:0] mem_next [WORDS];
   logic wen_reg, wen_next, busy_reg, busy_next;
   logic pend_reg, pend_next;
   logic [31:0] tmr_reg, tmr_next;
   logic do_reg, do_next, oe_n_reg, oe_n_next;

   assign cs_s = sync2_reg[0];
   assign sc_s = sync2_reg[1];
   assign sin_s = sync2_reg[2];
   assign cs_rise = cs_s && !cs_d_reg;
   assign cs_fall = !cs_s && cs_d_reg;
   assign sc_rise = sc_s && !sc_d_reg && cs_s;

   logic [1:0] op;
   logic [3:0] addr;
   assign op = hdr_reg[HDR_BITS-1 -: OPCODE_BITS];
   assign addr = hdr_reg[3:0];

   always_comb begin
      sync1_next = {link.serial_in, link.shift_clock, link.chip_select};
      sync2_next = sync1_reg;
      cs_d_next = cs_s;
      sc_d_next = sc_s;
      state_next = state_reg;
      cnt_next = cnt_reg;
      hdr_next = hdr_reg;
      sh_next = sh_reg;
      mem_next = mem_reg;
      wen_next = wen_reg;
      busy_next = busy_reg;
      pend_next = pend_reg;
      tmr_next = tmr_reg;
      do_next = do_reg;
      oe_n_next = !cs_s;
      // self-timed programming; busy lasts the full PROG_CYCLES
      if (busy_reg) begin
         if (tmr_reg >= 32'(PROG_CYCLES - 1)) begin
            busy_next = 1'b0;
            if (hdr_reg[HDR_BITS-1 -: OPCODE_BITS] == OP_WRITE) begin
               mem_next[addr] = sh_reg;
            end else if (op == OP_ERASE) begin
               mem_next[addr] = ERASED_WORD;
            end else begin
               for (int i = 0; i < WORDS; i++) begin
                  mem_next[i] = (hdr_reg[5:4] == EXT_WRALL) ?
                     sh_reg : ERASED_WORD;
               end
            end
         end else begin
            tmr_next = tmr_reg + 32'd1;
         end
      end
      if (cs_rise) begin
         state_next = S_IDLE;
         cnt_next = 5'd0;
         pend_next = 1'b0;
      end else if (cs_fall) begin
         state_next = S_IDLE;
         if (pend_reg && !busy_reg) begin
            busy_next = 1'b1;
            tmr_next = 32'd0;
         end
         pend_next = 1'b0;
      end else if (cs_s && busy_reg) begin
         do_next = 1'b0;
      end else if (cs_s) begin
         if (state_reg != S_READ) begin
            do_next = 1'b1; // ready
         end
         if (sc_rise) begin
            case (state_reg)
               S_IDLE: begin
                  if (sin_s) begin
                     state_next = S_HDR;
                     cnt_next = 5'd0;
                  end
               end
               S_HDR: begin
                  hdr_next = {hdr_reg[HDR_BITS-2:0], sin_s};
                  cnt_next = cnt_reg + 5'd1;
                  if (cnt_reg == 5'(HDR_BITS - 1)) begin
                     cnt_next = 5'd0;
                     state_next = S_DONE;
                     case (hdr_reg[HDR_BITS-2 -: OPCODE_BITS])
                        OP_READ: begin
                           state_next = S_READ;
                           sh_next = mem_reg[{hdr_reg[2:0], sin_s}];
                           do_next = 1'b0;
                        end
                        OP_WRITE: state_next = S_DATA;
                        OP_ERASE: pend_next = wen_reg;
                        default: begin
                           case (hdr_reg[4:3])
                              EXT_ENABLE: wen_next = 1'b1;
                              EXT_DISABLE: wen_next = 1'b0;
                              EXT_WRALL: state_next = S_DATA;
                              default: pend_next = wen_reg;
                           endcase
                        end
                     endcase
                  end
               end
               S_DATA: begin
                  sh_next = {sh_reg[DATA_BITS-2:0], sin_s};
                  cnt_next = cnt_reg + 5'd1;
                  if (cnt_reg == 5'(DATA_BITS - 1)) begin
                     state_next = S_DONE;
                     pend_next = wen_reg;
                  end
               end
               S_READ: begin
                  do_next = sh_reg[DATA_BITS-1];
                  sh_next = {sh_reg[DATA_BITS-2:0], 1'b0};
                  cnt_next = cnt_reg + 5'd1;
                  if (cnt_reg == 5'(DATA_BITS)) begin
                     state_next = S_DONE;
                     do_next = 1'b1;
                  end
               end
               S_DONE: state_next = S_DONE;
               default: state_next = S_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         cs_d_reg <= 1'b0;
         sc_d_reg <= 1'b0;
         state_reg <= S_IDLE;
         cnt_reg <= 5'd0;
         hdr_reg <= '0;
         sh_reg <= '0;
         for (int i = 0; i < WORDS; i++) begin
            mem_reg[i] <= ERASED_WORD;
         end
         wen_reg <= 1'b0;
         busy_reg <= 1'b0;
         pend_reg <= 1'b0;
         tmr_reg <= 32'd0;
         do_reg <= 1'b1;
         oe_n_reg <= 1'b1;
      end else if (clk_en) begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         cs_d_reg <= cs_d_next;
         sc_d_reg <= sc_d_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         hdr_reg <= hdr_next;
         sh_reg <= sh_next;
         mem_reg <= mem_next;
         wen_reg <= wen_next;
         busy_reg <= busy_next;
         pend_reg <= pend_next;
         tmr_reg <= tmr_next;
         do_reg <= do_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign link.data_out = do_reg;
   assign link.data_out_oe_n = oe_n_reg;
   assign busy = busy_reg;
   assign write_enabled = wen_reg;
endmodule // serial_eeprom_dev

/* File: hw/serial_eeprom_if.sv */
// link wires between the serial master and the eeprom device
`timescale 1ns/1ps
interface serial_eeprom_if;
   logic chip_select;
   logic shift_clock;
   logic serial_in;
   logic data_out;
   logic data_out_oe_n;
   logic data_out_wire;
   assign data_out_wire = data_out_oe_n ? 1'b1 : data_out;
   modport device (
      input chip_select, shift_clock, serial_in,
      output data_out, data_out_oe_n
   );
   modport master (
      output chip_select, shift_clock, serial_in,
      input data_out_wire, data_out_oe_n
   );
endinterface

/* File: hw/serial_eeprom_master.sv */
// master end: runs one command frame per request on the serial link
`timescale 1ns/1ps
module serial_eeprom_master
   import serial_eeprom_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // link
   serial_eeprom_if.master link,
   // user request
   input wire logic req_valid,
   input wire logic [1:0] req_opcode,
   input wire logic [5:0] req_addr,
   input wire logic [15:0] req_data,
   // user answer
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic dev_ready
);
   typedef enum logic [1:0] {
      M_GAP = 2'b00, M_IDLE = 2'b01, M_SHIFT = 2'b11, M_HOLD = 2'b10
   } mst_state_t;
   localparam int FRAME_BITS = 1 + HDR_BITS + DATA_BITS + 1;

   mst_state_t state_reg, state_next;
   logic [15:0] tick_reg, tick_next;
   logic [5:0] bit_reg, bit_next, nbits_reg, nbits_next;
   logic [FRAME_BITS-1:0] out_reg, out_next;
   logic [15:0] in_reg, in_next;
   logic cs_reg, cs_next, sclk_reg, sclk_next, rd_reg, rd_next;
   logic rv_reg, rv_next, rdy_reg, rdy_next;
   logic s1_reg, s2_reg;

   always_comb begin
      state_next = state_reg;
      tick_next = tick_reg + 16'd1;
      bit_next = bit_reg;
      nbits_next = nbits_reg;
      out_next = out_reg;
      in_next = in_reg;
      cs_next = cs_reg;
      sclk_next = sclk_reg;
      rd_next = rd_reg;
      rv_next = 1'b0;
      rdy_next = rdy_reg;
      case (state_reg)
         M_GAP: begin // deselect gap
            if (tick_reg >= 16'(DESELECT_CYC)) begin
               state_next = M_IDLE;
            end
         end
         M_IDLE: begin
            if (req_valid) begin
               state_next = M_SHIFT;
               cs_next = 1'b1;
               tick_next = 16'd0;
               bit_next = 6'd0;
               rd_next = (req_opcode == OP_READ);
               out_next = {1'b1, req_opcode, req_addr, req_data, 1'b0};
               nbits_next = 6'(1 + HDR_BITS);
               if (req_opcode == OP_WRITE || (req_opcode == OP_EXT &&
                   req_addr[5:4] == EXT_WRALL)) begin
                  nbits_next = 6'(1 + HDR_BITS + DATA_BITS);
               end else if (req_opcode == OP_READ) begin
                  nbits_next = 6'(1 + HDR_BITS + 1 + DATA_BITS);
               end
            end
         end
         M_SHIFT: begin
            if (!sclk_reg && tick_reg >= 16'(HALF_CYC)) begin
               sclk_next = 1'b1;
               tick_next = 16'd0;
               // the bit seen here left the device on the previous rise
               if (rd_reg && bit_reg > 6'(1 + HDR_BITS)) begin
                  in_next = {in_reg[14:0], s2_reg};
               end
            end else if (sclk_reg && tick_reg >= 16'(HALF_CYC)) begin
               sclk_next = 1'b0;
               tick_next = 16'd0;
               bit_next = bit_reg + 6'd1;
               out_next = {out_reg[FRAME_BITS-2:0], 1'b0};
               if (bit_reg + 6'd1 == nbits_reg) begin
                  state_next = M_HOLD;
               end
            end
         end
         M_HOLD: begin
            if (tick_reg >= 16'(HALF_CYC)) begin
               // all sixteen read bits were taken on the rising edges
               rv_next = rd_reg;
               cs_next = 1'b0;
               state_next = M_GAP;
               tick_next = 16'd0;
            end
         end
         default: state_next = M_GAP;
      endcase
      // ready status sampled while selected and not reading
      if (cs_reg && !rd_reg && !link.data_out_oe_n) begin
         rdy_next = s2_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= M_GAP;
         tick_reg <= 16'd0;
         bit_reg <= 6'd0;
         nbits_reg <= 6'd0;
         out_reg <= '0;
         in_reg <= 16'h0000;
         cs_reg <= 1'b0;
         sclk_reg <= 1'b0;
         rd_reg <= 1'b0;
         rv_reg <= 1'b0;
         rdy_reg <= 1'b1;
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         tick_reg <= tick_next;
         bit_reg <= bit_next;
         nbits_reg <= nbits_next;
         out_reg <= out_next;
         in_reg <= in_next;
         cs_reg <= cs_next;
         sclk_reg <= sclk_next;
         rd_reg <= rd_next;
         rv_reg <= rv_next;
         rdy_reg <= rdy_next;
         s1_reg <= link.data_out_wire;
         s2_reg <= s1_reg;
      end
   end

   assign link.chip_select = cs_reg;
   assign link.shift_clock = sclk_reg;
   assign link.serial_in = out_reg[FRAME_BITS-1];
   assign req_ready = (state_reg == M_IDLE);
   assign rsp_valid = rv_reg;
   assign rsp_data = in_reg;
   assign dev_ready = rdy_reg;
endmodule // serial_eeprom_master

/* File: hw/serial_eeprom_pkg.sv */
// shared constants for the serial eeprom link ends
package serial_eeprom_pkg;
   // system clock period and link timing, in their printed units
   localparam int CLK_PERIOD_NS = 8;
   localparam int DESELECT_MIN_TIME_US = 1;
   localparam int CLOCK_HIGH_PHASE_US = 1;
   localparam int CLOCK_LOW_PHASE_US = 1;
   localparam int SHIFT_CLOCK_RATE_KHZ = 250;
   localparam int PROGRAM_CYCLE_TIME_MS = 15;
   // derived cycle counts: least times round up, longest rounds down
   localparam int DESELECT_CYC =
      (DESELECT_MIN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC =
      (CLOCK_HIGH_PHASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CYC =
      (CLOCK_LOW_PHASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PERIOD_CYC =
      (1000000 / SHIFT_CLOCK_RATE_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_CYC = (PERIOD_CYC + 1) / 2;
   localparam int PROGRAM_CYC =
      (PROGRAM_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   // frame layout
   localparam int OPCODE_BITS = 2;
   localparam int ADDR_BITS = 6;
   localparam int DATA_BITS = 16;
   localparam int WORDS = 16;
   localparam int HDR_BITS = OPCODE_BITS + ADDR_BITS;
   // opcodes
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   // address high bits under OP_EXT
   localparam logic [1:0] EXT_DISABLE = 2'h0;
   localparam logic [1:0] EXT_WRALL = 2'h1;
   localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
   localparam logic [1:0] EXT_ENABLE = 2'h3;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
endpackage
